// [hdl/ios_pkg.sv]
// shared constants, types and helpers for the io space block
// assumes one 20 MHz clock and a synchronous active-high reset
`default_nettype none
package ios_pkg;
  localparam int IO_AW = 6;
  localparam int IO_SPACE = 64;
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] BIT_LAST = 8'h1F;
  localparam logic [7:0] IO_MEM_BASE = 8'h20;
  localparam logic [7:0] IO_MEM_LAST = 8'h5F;
  // io offsets
  localparam logic [5:0] REG_BAUD_RATE_HIGH = 6'h03;
  localparam logic [5:0] REG_CONV_RESULT_LOW = 6'h04;
  localparam logic [5:0] REG_CONV_RESULT_HIGH = 6'h05;
  localparam logic [5:0] REG_CONV_CONTROL_STATUS = 6'h06;
  localparam logic [5:0] REG_CONV_CHANNEL_SELECT = 6'h07;
  localparam logic [5:0] REG_COMPARATOR_CONTROL_STATUS = 6'h08;
  localparam logic [5:0] REG_BAUD_RATE_LOW = 6'h09;
  localparam logic [5:0] REG_SERIAL_CONTROL_B = 6'h0A;
  localparam logic [5:0] REG_SERIAL_STATUS_A = 6'h0B;
  localparam logic [5:0] REG_SERIAL_DATA = 6'h0C;
  localparam logic [5:0] REG_SYNC_SERIAL_CONTROL = 6'h0D;
  localparam logic [5:0] REG_SYNC_SERIAL_STATUS = 6'h0E;
  localparam logic [5:0] REG_SYNC_SERIAL_DATA = 6'h0F;
  localparam logic [5:0] REG_PORT_D_INPUTS = 6'h10;
  localparam logic [5:0] REG_PORT_D_DIRECTION = 6'h11;
  localparam logic [5:0] REG_PORT_D_OUTPUT = 6'h12;
  localparam logic [5:0] REG_PORT_C_INPUTS = 6'h13;
  localparam logic [5:0] REG_PORT_C_DIRECTION = 6'h14;
  localparam logic [5:0] REG_PORT_C_OUTPUT = 6'h15;
  localparam logic [5:0] REG_PORT_B_INPUTS = 6'h16;
  localparam logic [5:0] REG_PORT_B_DIRECTION = 6'h17;
  localparam logic [5:0] REG_PORT_B_OUTPUT = 6'h18;
  localparam logic [5:0] REG_NVM_CONTROL = 6'h1C;
  localparam logic [5:0] REG_NVM_DATA = 6'h1D;
  localparam logic [5:0] REG_NVM_ADDRESS = 6'h1E;
  localparam logic [5:0] REG_WATCHDOG_CONTROL = 6'h21;
  localparam logic [5:0] REG_CAPTURE_VALUE_LOW = 6'h26;
  localparam logic [5:0] REG_CAPTURE_VALUE_HIGH = 6'h27;
  localparam logic [5:0] REG_COMPARE_VALUE_LOW = 6'h2A;
  localparam logic [5:0] REG_COMPARE_VALUE_HIGH = 6'h2B;
  localparam logic [5:0] REG_WIDE_COUNTER_LOW = 6'h2C;
  localparam logic [5:0] REG_WIDE_COUNTER_HIGH = 6'h2D;
  localparam logic [5:0] REG_WIDE_COUNTER_CONTROL_B = 6'h2E;
  localparam logic [5:0] REG_WIDE_COUNTER_CONTROL_A = 6'h2F;
  localparam logic [5:0] REG_BYTE_COUNTER_VALUE = 6'h32;
  localparam logic [5:0] REG_BYTE_COUNTER_CONTROL = 6'h33;
  localparam logic [5:0] REG_RESET_CAUSE_STATUS = 6'h34;
  localparam logic [5:0] REG_CPU_GENERAL_CONTROL = 6'h35;
  localparam logic [5:0] REG_TIMER_IRQ_FLAGS = 6'h38;
  localparam logic [5:0] REG_TIMER_IRQ_MASK = 6'h39;
  localparam logic [5:0] REG_EXTERNAL_IRQ_FLAGS = 6'h3A;
  localparam logic [5:0] REG_EXTERNAL_IRQ_MASK = 6'h3B;
  localparam logic [5:0] REG_STACK_TOP_POINTER = 6'h3D;
  localparam logic [5:0] REG_PROCESSOR_FLAGS = 6'h3F;
  // one bit per io offset: present, read-only, write-one-to-clear
  localparam logic [63:0] MAP_MASK = 64'hAF3C_FCC2_71FF_FFF8;
  localparam logic [63:0] RO_MASK = 64'h0000_00C0_0049_0030;
  localparam logic [63:0] W1C_MASK = 64'h0500_0000_0000_0000;
  localparam logic [7:0] IO_RESET = 8'h00;
  // processor_flags bit positions
  localparam int FL_I = 7;
  localparam int FL_T = 6;
  localparam int FL_H = 5;
  localparam int FL_S = 4;
  localparam int FL_V = 3;
  localparam int FL_N = 2;
  localparam int FL_Z = 1;
  localparam int FL_C = 0;
  // controller register map and fields
  localparam logic [2:0] HR_CMD = 3'h0;
  localparam logic [2:0] HR_ADDR = 3'h1;
  localparam logic [2:0] HR_DATA = 3'h2;
  localparam logic [2:0] HR_ALU = 3'h3;
  localparam logic [2:0] HR_RESULT = 3'h4;
  localparam logic [2:0] HR_STATUS = 3'h5;
  localparam int CMD_BIT_LSB = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_SKIP = 1;
  localparam int ST_ERR = 2;
  localparam int ST_TOUT = 3;
  localparam int ST_DONE = 4;
  localparam int ALU_C = 0;
  localparam int ALU_H = 1;
  localparam int ALU_V = 2;
  localparam int ALU_T = 3;

  typedef enum logic [3:0] {
    io_read_op = 4'h0,
    io_write_op = 4'h1,
    mem_read_op = 4'h2,
    mem_write_op = 4'h3,
    set_io_bit_op = 4'h4,
    clear_io_bit_op = 4'h5,
    skip_if_io_bit_set_op = 4'h6,
    skip_if_io_bit_clear_op = 4'h7,
    reg_bit_save_op = 4'h8,
    reg_bit_restore_op = 4'h9,
    alu_flags_op = 4'hA,
    interrupt_take_op = 4'hB,
    interrupt_return_op = 4'hC
  } ios_op_e;

  function automatic logic ios_mem_hits_io(input logic [7:0] a);
    return (a >= IO_MEM_BASE) && (a <= IO_MEM_LAST);
  endfunction

  function automatic logic [5:0] ios_io_of_mem(input logic [7:0] a);
    logic [7:0] d;
    d = a - IO_MEM_BASE;
    return d[5:0];
  endfunction

  function automatic logic [7:0] ios_bit_mask(input logic [2:0] n);
    return 8'h01 << n;
  endfunction
endpackage
`default_nettype wire

// [hdl/ios_link.sv]
// link between the processor core end and the io space end
// assumes both ends on CLK; one request, answer exactly one cycle later
`default_nettype none
interface ios_link;
  import ios_pkg::*;
  logic req;
  ios_op_e op;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [2:0] bitn;
  logic cin;
  logic hin;
  logic vin;
  logic tin;
  logic ack;
  logic [7:0] rdata;
  logic skip;
  logic tout;
  logic err;
  modport core (
    output req, op, addr, wdata, bitn, cin, hin, vin, tin,
    input ack, rdata, skip, tout, err
  );
  modport dev (
    input req, op, addr, wdata, bitn, cin, hin, vin, tin,
    output ack, rdata, skip, tout, err
  );
endinterface
`default_nettype wire

// [hdl/ios_flags.sv]
// processor_flags register with its hardware update paths
// assumes one update source per cycle, chosen by the io space end
`default_nettype none
module ios_flags
  import ios_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // updates
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic alu_en,
  input wire logic [7:0] res,
  input wire logic cin,
  input wire logic hin,
  input wire logic vin,
  input wire logic tsave_en,
  input wire logic tin,
  input wire logic int_take,
  input wire logic int_ret,
  // state
  output logic [7:0] flags
);
  logic n_new;
  logic v_new;

  always_comb
  begin
    n_new = flags[FL_N];
    v_new = flags[FL_V];
    if (wr_en)
    begin
      n_new = wr_data[FL_N];
      v_new = wr_data[FL_V];
    end
    else if (alu_en)
    begin
      n_new = res[7];
      v_new = vin;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      flags <= IO_RESET;
    else
    begin
      if (wr_en)
        flags <= wr_data;
      else if (alu_en)
      begin
        flags[FL_H] <= hin;
        flags[FL_Z] <= (res == 8'h00);
        flags[FL_C] <= cin;
      end
      else if (tsave_en)
        flags[FL_T] <= tin;
      else if (int_take)
        flags[FL_I] <= 1'b0;
      else if (int_ret)
        flags[FL_I] <= 1'b1;
      flags[FL_N] <= n_new;
      flags[FL_V] <= v_new;
      flags[FL_S] <= n_new ^ v_new;
    end
  end
endmodule
`default_nettype wire

// [hdl/ios_device.sv]
// io space end: 43 peripheral registers and processor_flags within 64 io offsets
// assumes the core end on the same clock issues one request at a time
// Contract
// - io moves carry a byte to a register
// - io move addresses stay within 0x00..0x3F
// - data address equals io address plus 0x20
// - bit set and clear only below 0x20
// - bit skip tests below 0x20
// - some flags clear by writing one
// - bit set or clear rewrites whole register
// - software writes reserved bits as zero
// - software never writes unused io addresses
// - processor flags live at io 0x3F
// - bit 7 clear blocks every interrupt
// - interrupt clears enable, return sets it
// - bit 6 holds the saved register bit
// - bit 5 records low nibble carry
// - bit 4 equals negative xor overflow
// - bit 3 records two's complement overflow
// - bit 2 records negative result
// - bit 1 records zero result
// - bit 0 records carry
// - flags never saved around interrupts
// - stack pointer, 8 bits, io 0x3D
`default_nettype none
module ios_device
  import ios_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // core link
  ios_link.dev LINK,
  // pins, synchronised here
  input wire logic [7:0] PIN_B,
  input wire logic [7:0] PIN_C,
  input wire logic [7:0] PIN_D,
  // peripheral values on CLK
  input wire logic [15:0] CONV_RESULT,
  input wire logic [15:0] CAPTURE_VALUE,
  input wire logic [7:0] TIMER_FLAG_SET,
  input wire logic [7:0] EXT_FLAG_SET,
  input wire logic IRQ_PENDING,
  // state out
  output logic [7:0] FLAGS,
  output logic [7:0] STACK_PTR,
  output logic INT_REQ,
  output logic [7:0] PORT_B_OUT,
  output logic [7:0] PORT_B_DIR,
  output logic [7:0] PORT_C_OUT,
  output logic [7:0] PORT_C_DIR,
  output logic [7:0] PORT_D_OUT,
  output logic [7:0] PORT_D_DIR
);
  logic [7:0] io_mem [IO_SPACE];
  logic [2:0][7:0] pin_meta;
  logic [2:0][7:0] pin_sync;
  logic [7:0] flags;
  logic is_mem;
  logic is_bit;
  logic is_wr;
  logic addr_ok;
  logic bad;
  logic do_wr;
  logic [5:0] a6;
  logic [7:0] cur;
  logic [7:0] wval;
  logic [7:0] bmask;
  logic go;

  assign go = LINK.req;
  assign bmask = ios_bit_mask(LINK.bitn);

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {PIN_D, PIN_C, PIN_B};
      pin_sync <= pin_meta;
    end
  end

  // address decode
  always_comb
  begin
    is_mem = LINK.op inside {mem_read_op, mem_write_op};
    is_bit = LINK.op inside {set_io_bit_op, clear_io_bit_op,
      skip_if_io_bit_set_op, skip_if_io_bit_clear_op};
    is_wr = LINK.op inside {io_write_op, mem_write_op, set_io_bit_op,
      clear_io_bit_op};
    if (is_mem)
    begin
      a6 = ios_io_of_mem(LINK.addr);
      addr_ok = ios_mem_hits_io(LINK.addr);
    end
    else
    begin
      a6 = LINK.addr[IO_AW-1:0];
      addr_ok = LINK.addr <= IO_LAST;
    end
    if (is_bit && (LINK.addr > BIT_LAST))
      addr_ok = 1'b0;
  end

  // read view of the addressed register
  always_comb
  begin
    cur = MAP_MASK[a6] ? io_mem[a6] : IO_RESET;
    unique case (a6)
      REG_PORT_B_INPUTS: cur = pin_sync[0];
      REG_PORT_C_INPUTS: cur = pin_sync[1];
      REG_PORT_D_INPUTS: cur = pin_sync[2];
      REG_CONV_RESULT_LOW: cur = CONV_RESULT[7:0];
      REG_CONV_RESULT_HIGH: cur = CONV_RESULT[15:8];
      REG_CAPTURE_VALUE_LOW: cur = CAPTURE_VALUE[7:0];
      REG_CAPTURE_VALUE_HIGH: cur = CAPTURE_VALUE[15:8];
      REG_PROCESSOR_FLAGS: cur = flags;
      default: ;
    endcase
  end

  // value written back, whole register for bit ops
  always_comb
  begin
    unique case (LINK.op)
      set_io_bit_op: wval = cur | bmask;
      clear_io_bit_op: wval = cur & ~bmask;
      default: wval = LINK.wdata;
    endcase
  end

  always_comb
  begin
    bad = 1'b0;
    if (is_mem || is_bit || LINK.op inside {io_read_op, io_write_op})
      bad = !addr_ok;
    if (LINK.op == interrupt_take_op)
      bad = !flags[FL_I];
    do_wr = go && is_wr && !bad && MAP_MASK[a6] && !RO_MASK[a6];
  end

  // peripheral register storage
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      for (int i = 0; i < IO_SPACE; i++)
        io_mem[i] <= IO_RESET;
    end
    else
    begin
      for (int i = 0; i < IO_SPACE; i++)
      begin
        if (W1C_MASK[i])
        begin
          // set pulse wins over a same-cycle clear
          io_mem[i] <= (io_mem[i] & ~((do_wr && (a6 == i)) ? wval : 8'h00))
            | ((i == REG_TIMER_IRQ_FLAGS) ? TIMER_FLAG_SET : EXT_FLAG_SET);
        end
        else if (do_wr && (a6 == i) && (i != REG_PROCESSOR_FLAGS))
          io_mem[i] <= wval;
      end
    end
  end

  ios_flags u_flags (
    .clk(CLK),
    .rst(RST),
    .wr_en(do_wr && (a6 == REG_PROCESSOR_FLAGS)),
    .wr_data(wval),
    .alu_en(go && (LINK.op == alu_flags_op)),
    .res(LINK.wdata),
    .cin(LINK.cin),
    .hin(LINK.hin),
    .vin(LINK.vin),
    .tsave_en(go && (LINK.op == reg_bit_save_op)),
    .tin(LINK.tin),
    .int_take(go && !bad && (LINK.op == interrupt_take_op)),
    .int_ret(go && (LINK.op == interrupt_return_op)),
    .flags(flags)
  );
  // interrupt entry and return touch only the enable bit

  // answer, one cycle after the request
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      LINK.ack <= 1'b0;
      LINK.rdata <= IO_RESET;
      LINK.skip <= 1'b0;
      LINK.tout <= 1'b0;
      LINK.err <= 1'b0;
    end
    else
    begin
      LINK.ack <= go;
      LINK.err <= go && bad;
      LINK.tout <= flags[FL_T];
      LINK.skip <= 1'b0;
      LINK.rdata <= IO_RESET;
      if (go && !bad)
      begin
        if (LINK.op == skip_if_io_bit_set_op)
          LINK.skip <= (cur & bmask) != 8'h00;
        if (LINK.op == skip_if_io_bit_clear_op)
          LINK.skip <= (cur & bmask) == 8'h00;
        if (LINK.op inside {io_read_op, mem_read_op})
          LINK.rdata <= cur;
        if (LINK.op == reg_bit_restore_op)
          LINK.rdata <= flags[FL_T] ? (LINK.wdata | bmask)
            : (LINK.wdata & ~bmask);
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      INT_REQ <= 1'b0;
    else
      INT_REQ <= flags[FL_I] && IRQ_PENDING;
  end

  assign FLAGS = flags;
  assign STACK_PTR = io_mem[REG_STACK_TOP_POINTER];
  assign PORT_B_OUT = io_mem[REG_PORT_B_OUTPUT];
  assign PORT_B_DIR = io_mem[REG_PORT_B_DIRECTION];
  assign PORT_C_OUT = io_mem[REG_PORT_C_OUTPUT];
  assign PORT_C_DIR = io_mem[REG_PORT_C_DIRECTION];
  assign PORT_D_OUT = io_mem[REG_PORT_D_OUTPUT];
  assign PORT_D_DIR = io_mem[REG_PORT_D_DIRECTION];
endmodule
`default_nettype wire

// [hdl/ios_host.sv]
// core end: issues io space requests ordered through its own registers
// assumes a software port with read data one cycle after the read strobe
`default_nettype none
module ios_host
  import ios_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // software register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // link to the io space
  ios_link.core LINK
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } ios_hstate_e;

  ios_hstate_e state;
  logic [7:0] addr;
  logic [7:0] data;
  logic [3:0] alu;
  logic [7:0] result;
  logic [4:0] status;
  logic launch;
  logic bad;
  ios_op_e next_op;

  always_comb
  begin
    next_op = ios_op_e'(REG_WDATA[CMD_BIT_LSB-1:0]);
    launch = REG_WR && (REG_ADDR == HR_CMD) && (state == H_IDLE);
    bad = 1'b0;
    if (next_op inside {io_read_op, io_write_op})
      bad = addr > IO_LAST;
    if (next_op == io_write_op)
      bad = bad || !MAP_MASK[addr[IO_AW-1:0]];
    if (next_op == mem_write_op)
      bad = !ios_mem_hits_io(addr)
        || !MAP_MASK[ios_io_of_mem(addr)];
  end

  // data is passed as software wrote it, reserved bits included
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      addr <= 8'h00;
      data <= 8'h00;
      alu <= 4'h0;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == HR_ADDR)
        addr <= REG_WDATA;
      if (REG_ADDR == HR_DATA)
        data <= REG_WDATA;
      if (REG_ADDR == HR_ALU)
        alu <= REG_WDATA[3:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state <= H_IDLE;
      status <= 5'h00;
      result <= 8'h00;
      LINK.req <= 1'b0;
      LINK.op <= io_read_op;
      LINK.addr <= 8'h00;
      LINK.wdata <= 8'h00;
      LINK.bitn <= 3'h0;
      LINK.cin <= 1'b0;
      LINK.hin <= 1'b0;
      LINK.vin <= 1'b0;
      LINK.tin <= 1'b0;
    end
    else
    begin
      LINK.req <= 1'b0;
      unique case (state)
        H_IDLE:
        begin
          if (launch && bad)
            status <= 5'h00 | (5'h01 << ST_ERR) | (5'h01 << ST_DONE);
          else if (launch)
          begin
            LINK.req <= 1'b1;
            LINK.op <= next_op;
            LINK.addr <= addr;
            LINK.wdata <= data;
            LINK.bitn <= REG_WDATA[CMD_BIT_LSB+2:CMD_BIT_LSB];
            LINK.cin <= alu[ALU_C];
            LINK.hin <= alu[ALU_H];
            LINK.vin <= alu[ALU_V];
            LINK.tin <= alu[ALU_T];
            status <= 5'h01 << ST_BUSY;
            state <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          if (LINK.ack)
          begin
            result <= LINK.rdata;
            status <= ({4'h0, LINK.skip} << ST_SKIP)
              | ({4'h0, LINK.err} << ST_ERR)
              | ({4'h0, LINK.tout} << ST_TOUT)
              | (5'h01 << ST_DONE);
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // flags save and restore is left to the program issuing orders
  always_ff @(posedge CLK)
  begin
    if (RST)
      REG_RDATA <= 8'h00;
    else if (REG_RD)
    begin
      unique case (REG_ADDR)
        HR_ADDR: REG_RDATA <= addr;
        HR_DATA: REG_RDATA <= data;
        HR_ALU: REG_RDATA <= {4'h0, alu};
        HR_RESULT: REG_RDATA <= result;
        HR_STATUS: REG_RDATA <= {3'h0, status};
        default: REG_RDATA <= 8'h00;
      endcase
    end
    else
      REG_RDATA <= 8'h00;
  end
endmodule
`default_nettype wire

// [sim/ios_link_asserts.sv]
// concurrent checks on the link between core end and io space end
// assumes instantiation in tb beside the link, everything on CLK
`default_nettype none
module ios_link_asserts
  import ios_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // core side
  input wire logic req,
  input wire ios_op_e op,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] bitn,
  // device side
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic skip,
  input wire logic tout,
  input wire logic err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  property p_ack_follows;
    req |=> ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing after request");
  property p_ack_cause;
    ack |-> $past(req) && !$past(ack);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_idle_quiet;
    !ack |-> rdata == 8'h00 && !skip && !err;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("answer lines busy outside ack");
  property p_io_ok;
    req && (op == io_read_op || op == io_write_op) && addr <= IO_LAST
      |=> !err;
  endproperty
  a_io_ok: assert property (p_io_ok)
    else $error("legal io move refused");
  property p_mem_out;
    req && op == mem_read_op && (addr < 8'h20 || addr > 8'h5F) |=> err;
  endproperty
  a_mem_out: assert property (p_mem_out)
    else $error("data access outside io window accepted");
  property p_bit_range;
    req && (op == set_io_bit_op || op == clear_io_bit_op ||
      op == skip_if_io_bit_set_op || op == skip_if_io_bit_clear_op)
      |=> err == ($past(addr) > 8'h1F);
  endproperty
  a_bit_range: assert property (p_bit_range)
    else $error("bit op range decision wrong");
  property p_unmapped;
    req && op == io_read_op && addr <= IO_LAST && !MAP_MASK[addr[5:0]]
      |=> rdata == 8'h00 && !err;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_sign;
    req && ((op == io_read_op && addr == 8'h3F) ||
      (op == mem_read_op && addr == 8'h5F))
      |=> rdata[4] == (rdata[2] ^ rdata[3]);
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign bit not n xor v");
  property p_restore;
    req && op == reg_bit_restore_op |=> rdata ==
      (($past(wdata) & ~(8'h01 << $past(bitn))) |
      ({7'h00, tout} << $past(bitn)));
  endproperty
  a_restore: assert property (p_restore)
    else $error("bit restore result wrong");
  c_write: cover property (req && op == io_write_op);
  c_skip: cover property (skip);
  c_err: cover property (err);
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench: core end and io space end joined by the link
// assumes hdl/ files compiled first; software port drives every link request, pins, flag sets and irq driven directly
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ios_pkg::*;
  logic CLK;
  logic RST;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] pin_b;
  logic [15:0] conv;
  logic [7:0] tflag;
  logic irq;
  logic [7:0] flags;
  logic [7:0] sp;
  logic int_req;
  logic [7:0] pbo;
  logic [7:0] pbd;
  logic [7:0] pdo;
  logic [7:0] pdd;
  logic [7:0] pco;
  logic [7:0] pcd;
  logic [7:0] st;
  logic [7:0] res;
  logic [7:0] fl;
  logic [11:0] alu_tab [4];
  int err_count;
  int comparisons;
  ios_link lnk();
  ios_host ios_host_i (.CLK(CLK), .RST(RST), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .LINK(lnk));
  ios_device ios_device_i (.CLK(CLK), .RST(RST), .LINK(lnk),
    .PIN_B(pin_b), .PIN_C(8'h00), .PIN_D(8'h00), .CONV_RESULT(conv),
    .CAPTURE_VALUE(16'h0000), .TIMER_FLAG_SET(tflag),
    .EXT_FLAG_SET(tflag), .IRQ_PENDING(irq), .FLAGS(flags),
    .STACK_PTR(sp), .INT_REQ(int_req), .PORT_B_OUT(pbo),
    .PORT_B_DIR(pbd), .PORT_C_OUT(pco), .PORT_C_DIR(pcd), .PORT_D_OUT(pdo),
    .PORT_D_DIR(pdd));
  ios_link_asserts ios_link_asserts_i (.CLK(CLK), .RST(RST),
    .req(lnk.req), .op(lnk.op), .addr(lnk.addr), .wdata(lnk.wdata),
    .bitn(lnk.bitn), .ack(lnk.ack), .rdata(lnk.rdata), .skip(lnk.skip),
    .tout(lnk.tout), .err(lnk.err));
  initial
  begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge CLK);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge CLK);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge CLK);
    reg_rd <= 1'b0;
    @(posedge CLK);
    d = reg_rdata;
  endtask
  // one command: operands, launch, poll done, fetch result
  task automatic run(input ios_op_e o, input logic [7:0] a, d,
    input logic [2:0] b, input logic [3:0] alu);
    int n;
    wr(HR_ADDR, a);
    wr(HR_DATA, d);
    wr(HR_ALU, {4'h0, alu});
    wr(HR_CMD, {1'b0, b, o});
    n = 0;
    st = 8'h00;
    while (st[ST_DONE] !== 1'b1 && n < 20)
    begin
      rd(HR_STATUS, st);
      n++;
    end
    chk("done", {7'h00, st[ST_DONE]}, 8'h01);
    rd(HR_RESULT, res);
  endtask
  initial
  begin
    repeat (20000) @(posedge CLK);
    err_count++;
    give_verdict();
  end
  initial
  begin
    RST = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pin_b = 8'h3C;
    conv = 16'h1234;
    tflag = 8'h00;
    irq = 1'b0;
    alu_tab = '{12'h800, 12'h001, 12'h7F4, 12'h0F2};
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    fl = 8'h00;
    chk("flags reset", flags, 8'h00);
    run(io_write_op, 8'h18, 8'h55, 3'd0, 4'h0);
    chk("port b out", pbo, 8'h55);
    run(io_read_op, 8'h18, 8'h00, 3'd0, 4'h0);
    chk("io read", res, 8'h55);
    run(mem_write_op, 8'h37, 8'hA5, 3'd0, 4'h0);
    chk("mem write", pbd, 8'hA5);
    run(mem_read_op, 8'h38, 8'h00, 3'd0, 4'h0);
    chk("mem read", res, 8'h55);
    run(mem_read_op, 8'h60, 8'h00, 3'd0, 4'h0);
    chk("mem outside", {7'h00, st[ST_ERR]}, 8'h01);
    run(io_read_op, 8'h40, 8'h00, 3'd0, 4'h0);
    chk("io range", {7'h00, st[ST_ERR]}, 8'h01);
    run(io_read_op, 8'h00, 8'h00, 3'd0, 4'h0);
    chk("unmapped", res, 8'h00);
    run(io_write_op, 8'h00, 8'h77, 3'd0, 4'h0);
    chk("unmapped wr", {7'h00, st[ST_ERR]}, 8'h01);
    run(io_write_op, 8'h3D, 8'hC3, 3'd0, 4'h0);
    chk("stack ptr", sp, 8'hC3);
    run(mem_read_op, 8'h5D, 8'h00, 3'd0, 4'h0);
    chk("stack mem", res, 8'hC3);
    run(io_write_op, 8'h04, 8'hFF, 3'd0, 4'h0);
    run(io_read_op, 8'h04, 8'h00, 3'd0, 4'h0);
    chk("conv low", res, 8'h34);
    run(io_read_op, 8'h16, 8'h00, 3'd0, 4'h0);
    chk("pins b", res, 8'h3C);
    run(io_write_op, 8'h15, 8'h3A, 3'd0, 4'h0);
    chk("port c out", pco, 8'h3A);
    run(mem_write_op, 8'h34, 8'h6B, 3'd0, 4'h0);
    chk("port c dir", pcd, 8'h6B);
    run(io_write_op, 8'h11, 8'h9E, 3'd0, 4'h0);
    chk("port d dir", pdd, 8'h9E);
    $display("test moves done");
    run(io_write_op, 8'h12, 8'h50, 3'd0, 4'h0);
    run(set_io_bit_op, 8'h12, 8'h00, 3'd0, 4'h0);
    chk("bit set", pdo, 8'h51);
    run(clear_io_bit_op, 8'h12, 8'h00, 3'd4, 4'h0);
    chk("bit clear", pdo, 8'h41);
    run(set_io_bit_op, 8'h21, 8'h00, 3'd0, 4'h0);
    chk("bit range", {7'h00, st[ST_ERR]}, 8'h01);
    for (int b = 0; b < 2; b++)
    begin
      run(skip_if_io_bit_set_op, 8'h12, 8'h00, 3'(b), 4'h0);
      chk("skip set", {7'h00, st[ST_SKIP]}, 8'(b == 0));
      run(skip_if_io_bit_clear_op, 8'h12, 8'h00, 3'(b), 4'h0);
      chk("skip clr", {7'h00, st[ST_SKIP]}, 8'(b != 0));
    end
    run(skip_if_io_bit_set_op, 8'h20, 8'h00, 3'd0, 4'h0);
    chk("skip range", {7'h00, st[ST_ERR]}, 8'h01);
    $display("test bits done");
    @(posedge CLK);
    tflag <= 8'h05;
    @(posedge CLK);
    tflag <= 8'h00;
    run(io_read_op, 8'h38, 8'h00, 3'd0, 4'h0);
    chk("flag set", res, 8'h05);
    run(io_write_op, 8'h38, 8'h00, 3'd0, 4'h0);
    run(io_read_op, 8'h38, 8'h00, 3'd0, 4'h0);
    chk("flag zero wr", res, 8'h05);
    run(io_write_op, 8'h38, 8'h04, 3'd0, 4'h0);
    run(io_read_op, 8'h38, 8'h00, 3'd0, 4'h0);
    chk("flag one wr", res, 8'h01);
    run(io_write_op, 8'h3A, 8'h01, 3'd0, 4'h0);
    run(io_read_op, 8'h3A, 8'h00, 3'd0, 4'h0);
    chk("ext flag", res, 8'h04);
    $display("test flags clear done");
    foreach (alu_tab[i])
    begin
      run(alu_flags_op, 8'h00, alu_tab[i][11:4], 3'd0, alu_tab[i][3:0]);
      fl = {fl[7:6], alu_tab[i][ALU_H], alu_tab[i][11] ^ alu_tab[i][ALU_V],
        alu_tab[i][ALU_V], alu_tab[i][11], alu_tab[i][11:4] == 8'h00,
        alu_tab[i][ALU_C]};
      chk("alu flags", flags, fl);
    end
    run(reg_bit_save_op, 8'h00, 8'h00, 3'd0, 4'h8);
    fl[FL_T] = 1'b1;
    chk("bit save", flags, fl);
    run(reg_bit_restore_op, 8'h00, 8'h00, 3'd5, 4'h0);
    chk("bit restore", res, 8'h20);
    run(io_write_op, 8'h3F, 8'h48, 3'd0, 4'h0);
    chk("sign rewrite", flags, 8'h58);
    run(io_read_op, 8'h3F, 8'h00, 3'd0, 4'h0);
    chk("flags io", res, 8'h58);
    run(mem_read_op, 8'h5F, 8'h00, 3'd0, 4'h0);
    chk("flags mem", res, 8'h58);
    $display("test status done");
    run(interrupt_take_op, 8'h00, 8'h00, 3'd0, 4'h0);
    chk("take refused", {7'h00, st[ST_ERR]}, 8'h01);
    irq <= 1'b1;
    run(io_write_op, 8'h3F, 8'hC8, 3'd0, 4'h0);
    chk("enable on", flags, 8'hD8);
    chk("irq out", {7'h00, int_req}, 8'h01);
    run(interrupt_take_op, 8'h00, 8'h00, 3'd0, 4'h0);
    chk("take", flags, 8'h58);
    chk("irq blocked", {7'h00, int_req}, 8'h00);
    run(interrupt_return_op, 8'h00, 8'h00, 3'd0, 4'h0);
    chk("return", flags, 8'hD8);
    $display("test interrupts done");
    give_verdict();
  end
endmodule
`default_nettype wire
